/* File: hdl/plr_top.sv */
// Link-side phy interface: request streams, control pair and AXI4-Lite registers.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
module plr_top #(
    parameter int unsigned DATA_W = 4
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              resetn,
    // AXI4-Lite write channels
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Interface clock from the phy
    input  wire logic              link_clock,
    // Control pair, two-way
    input  wire logic              control_pair_bit0_in,
    output logic                   control_pair_bit0_out,
    output logic                   control_pair_bit0_oe,
    input  wire logic              control_pair_bit1_in,
    output logic                   control_pair_bit1_out,
    output logic                   control_pair_bit1_oe,
    // Data bus, two-way
    input  wire logic [DATA_W-1:0] link_data_in,
    output logic [DATA_W-1:0]      link_data_out,
    output logic [DATA_W-1:0]      link_data_oe,
    // Request line
    output logic                   link_request_line
);
    import plr_pkg::*;

    logic [DATA_W+2:0] sync1_reg;
    logic [DATA_W+2:0] sync2_reg;
    logic              lclk_d_reg;
    logic [1:0]        ctl_smp_reg;
    logic [7:0]        rx_data_reg;
    logic              idle_prev_reg;
    plr_req_e          req_reg;
    plr_bus_e          bus_reg;
    plr_cmd_s          cmd_reg;
    logic              pend_reg;
    logic              lost_reg;
    logic [16:0]       shift_reg;
    logic [4:0]        cnt_reg;
    logic              link_request_line_reg;
    logic [1:0]        ctl_out_reg;
    logic              ctl_oe_reg;
    logic [DATA_W-1:0] dout_reg;
    logic [31:0]       txctl_reg;
    logic              aw_full_reg;
    logic              w_full_reg;
    logic [7:0]        awaddr_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              rvalid_reg;
    logic [31:0]       rdata_reg;
    logic [1:0]        rresp_reg;

    // Link-domain view, all through the two-flop synchroniser.
    wire              lclk_s    = sync2_reg[0];
    wire [1:0]        ctl_s     = sync2_reg[2:1];
    wire [DATA_W-1:0] data_s    = sync2_reg[DATA_W+2:3];
    wire              lrise     = lclk_s & ~lclk_d_reg;
    wire              lfall     = ~lclk_s & lclk_d_reg;
    wire              ctl_idle  = ctl_smp_reg == CTL_IDLE;
    wire              ctl_grant = ctl_smp_reg == CTL_GRANT;
    // Receive only counts as lost while the phy owns the pair.
    wire              rx_seen   = (ctl_smp_reg == CTL_RECEIVE) && (bus_reg == BUS_PHY);
    wire              arb       = plr_arb(cmd_reg.rtype);
    wire [16:0]       stream    = plr_stream(cmd_reg);
    wire [4:0]        stream_n  = plr_len(cmd_reg.rtype);
    wire              is_reg    = (cmd_reg.rtype == RT_READ) || (cmd_reg.rtype == RT_WRITE);
    wire              lost_now  = lrise && arb && rx_seen &&
                                  (req_reg == REQ_SHIFT || req_reg == REQ_WAIT_GRANT);
    wire              start_ok  = ctl_idle && idle_prev_reg;
    wire              shift_end = lrise && (req_reg == REQ_SHIFT) && (cnt_reg == stream_n);

    // A reserved hold code from software is clamped, so 11 is never driven.
    wire [1:0]        drv_code  = (txctl_reg[1:0] == 2'h3) ? DRV_HOLD : txctl_reg[1:0];

    // Register bus decode.
    wire              wr_fire   = aw_full_reg && w_full_reg && !bvalid_reg;
    wire              ar_fire   = s_axi_arvalid && !rvalid_reg;
    wire [31:0]       wmask     = plr_mask(wstrb_reg);
    wire [31:0]       req_old   = {8'h00, cmd_reg.data, 4'h0, cmd_reg.addr,
                                   2'h0, cmd_reg.speed, 1'b0, cmd_reg.rtype};
    wire [31:0]       req_new   = (req_old & ~wmask) | (wdata_reg & wmask);
    wire [2:0]        new_type  = req_new[2:0];
    wire [1:0]        new_speed = req_new[5:4];
    wire              new_bad   = (new_type > RT_WRITE) ||
                                  (new_speed == SPD_RESERVED && new_type < RT_READ);
    wire              wr_req    = wr_fire && (awaddr_reg == OFS_REQ);
    wire              req_ok    = wr_req && !pend_reg && !new_bad;
    wire              wr_tx     = wr_fire && (awaddr_reg == OFS_TXCTL);
    wire              wr_sts    = wr_fire && (awaddr_reg == OFS_STATUS);
    wire              lost_clr  = wr_sts && wstrb_reg[0] && wdata_reg[STS_LOST];
    wire              wr_err    = (wr_req && !req_ok) ||
                                  !(wr_req || wr_tx || wr_sts);
    wire [31:0]       status    = {16'h0000, rx_data_reg, 2'h0, ctl_smp_reg,
                                   lost_reg, ctl_oe_reg, req_reg == REQ_SHIFT, pend_reg};
    wire              rd_map    = (s_axi_araddr == OFS_REQ) || (s_axi_araddr == OFS_TXCTL) ||
                                  (s_axi_araddr == OFS_STATUS);
    wire [31:0]       rd_word   = (s_axi_araddr == OFS_REQ)    ? req_old :
                                  (s_axi_araddr == OFS_TXCTL)  ? txctl_reg :
                                  (s_axi_araddr == OFS_STATUS) ? status : 32'h0000_0000;

    assign s_axi_awready         = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready          = !w_full_reg && !bvalid_reg;
    assign s_axi_bvalid          = bvalid_reg;
    assign s_axi_bresp           = bresp_reg;
    assign s_axi_arready         = !rvalid_reg;
    assign s_axi_rvalid          = rvalid_reg;
    assign s_axi_rdata           = rdata_reg;
    assign s_axi_rresp           = rresp_reg;
    assign link_request_line     = link_request_line_reg;
    assign control_pair_bit0_out = ctl_out_reg[1];
    assign control_pair_bit1_out = ctl_out_reg[0];
    assign control_pair_bit0_oe  = ctl_oe_reg;
    assign control_pair_bit1_oe  = ctl_oe_reg;
    assign link_data_out         = dout_reg;
    assign link_data_oe          = {DATA_W{ctl_oe_reg}};

    // Clock, pair and data all cross together so they keep their relative timing.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sync1_reg  <= '0;
            sync2_reg  <= '0;
            lclk_d_reg <= 1'b0;
        end else begin
            sync1_reg  <= {link_data_in, control_pair_bit0_in, control_pair_bit1_in, link_clock};
            sync2_reg  <= sync1_reg;
            lclk_d_reg <= lclk_s;
        end
    end

    // Inputs are taken mid-cycle, at the falling edge, clear of the phy's launch edge.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctl_smp_reg <= CTL_IDLE;
            rx_data_reg <= 8'h00;
        end else if (lfall) begin
            ctl_smp_reg <= ctl_s;
            if (!ctl_oe_reg && (ctl_s == CTL_RECEIVE || ctl_s == CTL_STATUS)) begin
                rx_data_reg <= 8'(data_s);
            end
        end
    end

    // Request stream engine, advanced once per link clock rising edge.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            req_reg       <= REQ_IDLE;
            shift_reg     <= 17'h0_0000;
            cnt_reg       <= 5'h00;
            link_request_line_reg      <= 1'b0;
            idle_prev_reg <= 1'b0;
        end else if (lrise) begin
            idle_prev_reg <= ctl_idle;
            unique case (req_reg)
                REQ_IDLE: begin
                    if (pend_reg) begin
                        req_reg <= arb ? REQ_WAIT_IDLE : REQ_SHIFT;
                        if (!arb) begin
                            link_request_line_reg  <= stream[0];
                            shift_reg <= {1'b0, stream[16:1]};
                            cnt_reg   <= 5'h01;
                        end
                    end
                end
                REQ_WAIT_IDLE: begin
                    if (start_ok) begin
                        req_reg   <= REQ_SHIFT;
                        link_request_line_reg  <= stream[0];
                        shift_reg <= {1'b0, stream[16:1]};
                        cnt_reg   <= 5'h01;
                    end
                end
                REQ_SHIFT: begin
                    if (lost_now) begin
                        req_reg  <= REQ_WAIT_IDLE;
                        link_request_line_reg <= 1'b0;
                    end else if (cnt_reg == stream_n) begin
                        req_reg <= is_reg ? REQ_IDLE : REQ_WAIT_GRANT;
                    end else begin
                        link_request_line_reg  <= shift_reg[0];
                        shift_reg <= {1'b0, shift_reg[16:1]};
                        cnt_reg   <= cnt_reg + 5'h01;
                    end
                end
                REQ_WAIT_GRANT: begin
                    if (lost_now) begin
                        req_reg <= REQ_WAIT_IDLE;
                    end else if (ctl_grant) begin
                        req_reg <= REQ_IDLE;
                    end
                end
            endcase
        end
    end

    // One command at a time; it stays pending until sent, granted or lost and resent.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pend_reg <= 1'b0;
            cmd_reg  <= '0;
            lost_reg <= 1'b0;
        end else begin
            if (req_ok) begin
                pend_reg <= 1'b1;
                cmd_reg  <= plr_cmd_s'({req_new[23:16], req_new[11:8], new_speed, new_type});
            end else if ((shift_end && is_reg && !lost_now) ||
                         (lrise && req_reg == REQ_WAIT_GRANT && ctl_grant && !lost_now)) begin
                pend_reg <= 1'b0;
            end
            // A loss in the same cycle as the software clear is kept.
            if (lost_now) begin
                lost_reg <= 1'b1;
            end else if (lost_clr) begin
                lost_reg <= 1'b0;
            end
        end
    end

    // Control pair ownership after a grant; width and rate never depend on speed.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bus_reg     <= BUS_PHY;
            ctl_out_reg <= DRV_RELEASE;
            ctl_oe_reg  <= 1'b0;
            dout_reg    <= '0;
        end else if (lrise) begin
            unique case (bus_reg)
                BUS_PHY: begin
                    if (ctl_grant) begin
                        bus_reg     <= (drv_code == DRV_RELEASE) ? BUS_RELEASE : BUS_OWN;
                        ctl_out_reg <= drv_code;
                        ctl_oe_reg  <= 1'b1;
                        dout_reg    <= (drv_code == DRV_TRANSMIT) ? txctl_reg[DATA_W+7:8] : '0;
                    end
                end
                BUS_OWN: begin
                    ctl_out_reg <= drv_code;
                    dout_reg    <= (drv_code == DRV_TRANSMIT) ? txctl_reg[DATA_W+7:8] : '0;
                    if (drv_code == DRV_RELEASE) begin
                        bus_reg <= BUS_RELEASE;
                    end
                end
                BUS_RELEASE: begin
                    bus_reg     <= BUS_PHY;
                    ctl_out_reg <= DRV_RELEASE;
                    ctl_oe_reg  <= 1'b0;
                    dout_reg    <= '0;
                end
            endcase
        end
    end

    // Write side: address and data are taken in either order and answered together.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            txctl_reg   <= TXCTL_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                awaddr_reg  <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_err ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (wr_tx) begin
                txctl_reg <= ((txctl_reg & ~wmask) | (wdata_reg & wmask)) & 32'h0000_ff03;
            end
        end
    end

    // Read side: one read in flight, answered the cycle after the address.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Checks.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    logic [4:0] bits_seen_reg;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bits_seen_reg <= 5'h00;
        end else if (lrise && req_reg != REQ_SHIFT) begin
            bits_seen_reg <= 5'h01;
        end else if (lrise && req_reg == REQ_SHIFT && cnt_reg != stream_n) begin
            bits_seen_reg <= bits_seen_reg + 5'h01;
        end
    end

    sequence s_grant_seen;
        lrise && bus_reg == BUS_PHY && ctl_grant;
    endsequence

    sequence s_release_step;
        lrise && bus_reg == BUS_RELEASE;
    endsequence

    a_oe_after_grant: assert property ($rose(ctl_oe_reg) |-> $past(lrise && ctl_grant))
        else $error("Control pair driven without a grant.");
    a_oe_holds_grant: assert property (s_grant_seen |=> ctl_oe_reg)
        else $error("Grant did not take the control pair.");
    a_release_drop: assert property (s_release_step |=> !ctl_oe_reg && ctl_out_reg == 2'h0)
        else $error("Release did not free the control pair.");
    a_never_eleven: assert property (ctl_oe_reg |-> ctl_out_reg != 2'h3)
        else $error("Link drove the reserved pair code.");
    a_start_bit_one: assert property ($changed(req_reg) && req_reg == REQ_SHIFT |-> link_request_line_reg)
        else $error("Stream did not open with a one.");
    a_low_between: assert property (req_reg != REQ_SHIFT && $past(req_reg) != REQ_SHIFT
                                    |-> !link_request_line_reg)
        else $error("Request line high between streams.");
    a_stream_length: assert property (shift_end |-> bits_seen_reg == stream_n)
        else $error("Stream length wrong for its kind.");
    a_bit_per_edge: assert property ($changed(link_request_line_reg) |-> $past(lrise))
        else $error("Request line moved off a link clock edge.");
    a_arb_waits_idle: assert property (lrise && req_reg == REQ_WAIT_IDLE && !start_ok
                                       |=> req_reg == REQ_WAIT_IDLE)
        else $error("Arbitrated request started before idle.");
    a_lost_abort: assert property (lost_now |=> req_reg == REQ_WAIT_IDLE && lost_reg)
        else $error("Lost request not withdrawn.");
endmodule

/* File: hdl/plr_pkg.sv */
// Constants, types and stream helpers for the link-side phy request interface.
// Notes on behaviour
// - Link drives shared lines only after grant.
// - Data bus two lines per 100 Mbit/s; here all DATA_W lines are driven at every speed.
// - Control pair and clock never scale.
// - Link starts requests only; phy starts rest.
// - Granted link drives hold, transmit, release; never 11.
// - Link sends serial stream to request line.
// - Stream starts with 1, ends with 0.
// - Lengths: bus 7, read 9, write 17.
// - Bus request: type 1-3, speed 4-5, stop 6.
// - Read request: type, address 4-7, stop 8.
// - Write request: address, data 8-15, stop 16.
// - Type codes 000 to 101; 110, 111 reserved.
// - Speed codes 00, 01, 10; 11 reserved.
// - Arbitrated requests wait idle; receive means lost.
package plr_pkg;
    localparam logic [1:0] CTL_IDLE     = 2'h0;
    localparam logic [1:0] CTL_STATUS   = 2'h1;
    localparam logic [1:0] CTL_RECEIVE  = 2'h2;
    localparam logic [1:0] CTL_GRANT    = 2'h3;
    localparam logic [1:0] DRV_RELEASE  = 2'h0;
    localparam logic [1:0] DRV_HOLD     = 2'h1;
    localparam logic [1:0] DRV_TRANSMIT = 2'h2;
    localparam logic [2:0] RT_TAKEOVER  = 3'h0;
    localparam logic [2:0] RT_ISO       = 3'h1;
    localparam logic [2:0] RT_PRIORITY  = 3'h2;
    localparam logic [2:0] RT_FAIR      = 3'h3;
    localparam logic [2:0] RT_READ      = 3'h4;
    localparam logic [2:0] RT_WRITE     = 3'h5;
    localparam logic [1:0] SPD_RESERVED = 2'h3;
    localparam logic [4:0] LEN_BUS      = 5'h07;
    localparam logic [4:0] LEN_READ     = 5'h09;
    localparam logic [4:0] LEN_WRITE    = 5'h11;
    localparam int         POS_TYPE     = 1;
    localparam int         POS_SPEED    = 4;
    localparam int         POS_ADDR     = 4;
    localparam int         POS_DATA     = 8;
    localparam logic [7:0] OFS_REQ      = 8'h00;
    localparam logic [7:0] OFS_TXCTL    = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [31:0] TXCTL_RESET = 32'h0000_0001;
    localparam int         STS_PEND     = 0;
    localparam int         STS_SHIFT    = 1;
    localparam int         STS_OWN      = 2;
    localparam int         STS_LOST     = 3;
    localparam int         STS_CTL      = 4;
    localparam int         STS_RXDATA   = 8;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic [7:0] data;
        logic [3:0] addr;
        logic [1:0] speed;
        logic [2:0] rtype;
    } plr_cmd_s;

    typedef enum logic [1:0] {REQ_IDLE, REQ_WAIT_IDLE, REQ_SHIFT, REQ_WAIT_GRANT} plr_req_e;
    typedef enum logic [1:0] {BUS_PHY, BUS_OWN, BUS_RELEASE} plr_bus_e;

    // Fields go out most significant bit first; bit 0 of the result leaves first.
    function automatic logic [16:0] plr_stream(input plr_cmd_s c);
        logic [16:0] s;
        s = 17'h0_0001;
        for (int i = 0; i < 3; i++) begin
            s[POS_TYPE+i] = c.rtype[2-i];
        end
        if (c.rtype == RT_READ || c.rtype == RT_WRITE) begin
            for (int i = 0; i < 4; i++) begin
                s[POS_ADDR+i] = c.addr[3-i];
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                s[POS_SPEED+i] = c.speed[1-i];
            end
        end
        if (c.rtype == RT_WRITE) begin
            for (int i = 0; i < 8; i++) begin
                s[POS_DATA+i] = c.data[7-i];
            end
        end
        return s;
    endfunction

    function automatic logic [4:0] plr_len(input logic [2:0] t);
        return (t == RT_WRITE) ? LEN_WRITE : (t == RT_READ) ? LEN_READ : LEN_BUS;
    endfunction

    function automatic logic plr_arb(input logic [2:0] t);
        return (t == RT_PRIORITY) || (t == RT_FAIR);
    endfunction

    function automatic logic [31:0] plr_mask(input logic [3:0] strb);
        return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction
endpackage

/* File: test/plr_phy_model.sv */
// Behavioural phy side: free running interface clock and request stream capture.
`timescale 1ns/100ps
module plr_phy_model
    import plr_pkg::*;
(
    // Interface clock and pair level
    output logic            link_clock,
    input  wire logic [1:0] pair,
    // Request stream from the link
    input  wire logic       link_request_line,
    output logic [16:0]     last_stream,
    output logic [4:0]      last_len,
    output int              stream_cnt
);
    logic [16:0] buf_v;
    logic [4:0]  idx;
    logic [2:0]  ty;
    initial begin
        link_clock = 1'b0;
        forever #160 link_clock = ~link_clock;
    end
    initial begin
        idx = 5'h00;
        buf_v = 17'h0_0000;
        stream_cnt = 0;
    end
    // A receive code aborts capture, as the link must drop its request then.
    always @(posedge link_clock) begin
        ty = {buf_v[1], buf_v[2], buf_v[3]};
        if (pair == CTL_RECEIVE) begin
            idx = 5'h00;
            buf_v = 17'h0_0000;
        end else if (idx != 5'h00 || link_request_line) begin
            buf_v[idx] = link_request_line;
            idx = idx + 5'h01;
            if (idx == (ty == RT_WRITE ? LEN_WRITE : ty == RT_READ ? LEN_READ : LEN_BUS)) begin
                last_stream <= buf_v;
                last_len <= idx;
                stream_cnt <= stream_cnt + 1;
                idx = 5'h00;
                buf_v = 17'h0_0000;
            end
        end
    end
endmodule

/* File: test/tb_plr_top.sv */
// Self-checking bench for the link-side phy request interface.
`timescale 1ns/100ps
module tb_plr_top;
    import plr_pkg::*;
    logic        mclk, resetn, awv, wv, arv, lc, rq, b0o, b0e, b1o, b1e;
    logic        awr, wr, bv, arr, rv;
    logic [7:0]  awa, ara, rnd;
    logic [31:0] wd, rd;
    logic [1:0]  br, rr, code, pair;
    logic [3:0]  pd, ddo, doe, ddi;
    logic [16:0] ls;
    logic [4:0]  ll;
    int          sc, error_cnt, check_count, cyc;
    assign pair = {b0e ? b0o : code[1], b1e ? b1o : code[0]};
    assign ddi = (doe & ddo) | (~doe & pd);
    plr_top i_plr_top (.mclk(mclk), .resetn(resetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .link_clock(lc),
        .control_pair_bit0_in(pair[1]), .control_pair_bit0_out(b0o), .control_pair_bit0_oe(b0e),
        .control_pair_bit1_in(pair[0]), .control_pair_bit1_out(b1o), .control_pair_bit1_oe(b1e),
        .link_data_in(ddi), .link_data_out(ddo), .link_data_oe(doe), .link_request_line(rq));
    plr_phy_model i_plr_phy_model (.link_clock(lc), .pair(pair), .link_request_line(rq),
        .last_stream(ls), .last_len(ll), .stream_cnt(sc));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out;
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Ready is sampled mid-cycle, where it is settled, and acted on at the next rise.
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, b;
        b = 1'b0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        while (!b) begin
            @(negedge mclk);
            aw = awv & awr;
            w = wv & wr;
            b = bv;
            r = br;
            @(posedge mclk);
            if (aw) awv <= 1'b0;
            if (w) wv <= 1'b0;
        end
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, v;
        v = 1'b0;
        ara <= a;
        arv <= 1'b1;
        while (!v) begin
            @(negedge mclk);
            ar = arv & arr;
            v = rv;
            d = rd;
            r = rr;
            @(posedge mclk);
            if (ar) arv <= 1'b0;
        end
    endtask
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic [16:0] exp_s(input logic [2:0] t, input logic [1:0] s,
                                          input logic [3:0] a, input logic [7:0] d);
        logic [16:0] v;
        v = 17'h0_0001;
        {v[1], v[2], v[3]} = t;
        if (t[2]) {v[4], v[5], v[6], v[7]} = a;
        else {v[4], v[5]} = s;
        if (t == RT_WRITE) {v[8], v[9], v[10], v[11], v[12], v[13], v[14], v[15]} = d;
        return v;
    endfunction
    task automatic req(input logic [2:0] t, input logic [1:0] s, input logic [3:0] a,
                       input logic [7:0] d, input bit lose);
        int n0;
        logic [1:0] r;
        logic [31:0] x;
        n0 = sc;
        // A new request is refused while the last one is still pending.
        x = 32'h1;
        while (x[STS_PEND]) axr(OFS_STATUS, x, r);
        axw(OFS_REQ, {8'h00, d, 4'h0, a, 2'h0, s, 1'b0, t}, r);
        chk("req resp", {30'h0, r}, {30'h0, RESP_OKAY});
        if (lose) begin
            repeat (2) @(posedge lc);
            @(posedge mclk) code <= CTL_RECEIVE;
            repeat (3) @(posedge lc);
            @(posedge mclk) code <= CTL_IDLE;
            chk("lost line", {31'h0, rq}, 32'h0);
            axr(OFS_STATUS, x, r);
            chk("lost flag", {31'h0, x[STS_LOST]}, 32'h1);
            chk("rx data", {24'h0, x[STS_RXDATA+:8]}, {28'h0, pd});
            axw(OFS_STATUS, 32'h8, r);
            axr(OFS_STATUS, x, r);
            chk("lost clear", {31'h0, x[STS_LOST]}, 32'h0);
        end
        while (sc == n0) @(posedge mclk);
        chk("stream", {15'h0, ls}, {15'h0, exp_s(t, s, a, d)});
        chk("length", {27'h0, ll}, t == RT_WRITE ? 32'h11 : t == RT_READ ? 32'h9 : 32'h7);
        chk("line low", {31'h0, rq}, 32'h0);
        if (!t[2]) begin
            chk("oe before grant", {30'h0, b0e, b1e}, 32'h0);
            @(posedge mclk) code <= CTL_GRANT;
            repeat (2) @(posedge lc);
            @(posedge mclk) code <= CTL_IDLE;
            repeat (2) @(posedge lc);
            @(posedge mclk);
            chk("hold", {24'h0, doe, b0e, b1e, b0o, b1o}, {24'h0, 4'hf, 2'h3, DRV_HOLD});
            axw(OFS_TXCTL, {16'h0, rnd, 8'h02}, r);
            repeat (2) @(posedge lc);
            @(posedge mclk);
            chk("transmit", {22'h0, b0o, b1o, doe, ddo},
                {22'h0, DRV_TRANSMIT, 4'hf, rnd[3:0]});
            axw(OFS_TXCTL, 32'h0, r);
            repeat (4) @(posedge lc);
            @(posedge mclk);
            chk("released", {26'h0, doe, b0e, b1e}, 32'h0);
            axw(OFS_TXCTL, TXCTL_RESET, r);
        end
        $display("test request type %0d done", t);
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        {resetn, awv, wv, arv, awa, ara, wd, code, pd, cyc, error_cnt, check_count} = '0;
        rnd = 8'h59;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (6) @(posedge lc);
        @(posedge mclk);
        axr(OFS_TXCTL, d, r);
        chk("txctl reset", d, TXCTL_RESET);
        axr(8'h0c, d, r);
        chk("unmapped", {30'h0, r}, {30'h0, RESP_SLVERR});
        axw(OFS_REQ, 32'h6, r);
        chk("reserved type", {30'h0, r}, {30'h0, RESP_SLVERR});
        axw(OFS_REQ, 32'h33, r);
        chk("reserved speed", {30'h0, r}, {30'h0, RESP_SLVERR});
        $display("test refusals done");
        for (int k = 0; k < 12; k++) begin
            rnd = lfsr(rnd);
            pd <= rnd[3:0];
            req(3'(k % 6), 2'(k % 3), rnd[7:4], lfsr(rnd), k == 3);
        end
        close_out;
    end
endmodule
